// file: hw/dual_compare_timer.sv
// How it works
// - Free mode counts 0..0xFF then wraps
// - Free mode overflow flag at 0xFF
// - Modulo counts to period value, reloads zero
// - Down mode loads period, stops at zero
// - Up/down climbs to period, falls to zero
// - Up/down overflow flags at zero turnaround
// - Overflow irq needs mask and enable
// - Channel pin acts on compare match
// - Compare pins come straight from flops
// - Period compare write applies at zero
// - Second compare write applies at once
// - Compare sets flag; mask, enable gate irq
// - Up/down channel 0 flags at zero
// - Flags set regardless of masks
// - Mask set on pending flag requests irq
// - One vector per timer, 11 and 12
// - DMA trigger pulse per channel compare
// - Count readback at 0xCA, resets zero
// - Start bit runs or suspends counter
// - Clear bit zeroes counter, reads zero
// - Mode field selects four counting modes
module dual_compare_timer
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       timer_tick,
    input  wire logic [7:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_write,
    input  wire logic       bus_read,
    output logic      [7:0] bus_rdata,
    output logic      [3:0] compare_pin,
    output logic      [3:0] compare_pin_oe,
    output logic      [1:0] timer_irq,
    output logic      [4:0] first_vector,
    output logic      [4:0] second_vector,
    output logic            first_timer_ch0_dma_trigger,
    output logic            first_timer_ch1_dma_trigger,
    output logic            second_timer_ch0_dma_trigger,
    output logic            second_timer_ch1_dma_trigger
);
    import timer_pkg::*;

    // =========================================================
    // Tick synchroniser
    // =========================================================
    logic       tick_meta_reg;
    logic       tick_sync_reg;
    logic       tick_last_reg;
    logic       tick_edge;

    // Tick pin is foreign, two flops before use
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_meta_reg <= 1'b0;
            tick_sync_reg <= 1'b0;
            tick_last_reg <= 1'b0;
        end
        else
        begin
            tick_meta_reg <= timer_tick;
            tick_sync_reg <= tick_meta_reg;
            tick_last_reg <= tick_sync_reg;
        end
    end

    assign tick_edge = tick_sync_reg & ~tick_last_reg;

    // =========================================================
    // Per timer state (index 0 first, 1 second)
    // =========================================================
    logic [7:0] count_reg          [2];
    logic [2:0] div_reg            [2];
    logic       start_reg          [2];
    logic       ovf_mask_reg       [2];
    logic [1:0] mode_reg           [2];
    logic       down_dir_reg       [2];
    logic       down_loaded_reg    [2];
    logic [7:0] prescale_reg       [2];
    logic [7:0] period_buf_reg     [2];
    logic [7:0] period_compare_reg [2];
    logic [7:0] second_compare_reg [2];
    logic       chan_mask_reg      [4];
    logic [2:0] compare_action_reg [4];
    logic       pin_reg            [4];
    logic [1:0] cpu_enable_reg;
    logic [5:0] timer_flag_reg;
    logic [1:0] cpu_timer_flag_reg;
    logic [3:0] dma_reg;

    logic       active_edge        [2];
    logic [7:0] count_next         [2];
    logic       ovf_event          [2];
    logic       ch_event           [4];
    logic       timer_sel;
    logic [7:0] local_addr;
    logic       in_range;

    // Any flag of one timer whose mask is set
    function automatic logic pending(input logic [2:0] f, input logic [2:0] m);
        pending = |(f & m);
    endfunction

    assign timer_sel  = (bus_addr >= ADDR_COUNT_READBACK + INSTANCE_STRIDE)
                      & (bus_addr <  ADDR_TIMER_FLAG);
    assign local_addr = timer_sel ? bus_addr - INSTANCE_STRIDE : bus_addr;
    assign in_range   = (local_addr >= ADDR_COUNT_READBACK)
                      & (local_addr <= ADDR_SECOND_COMPARE);

    // =========================================================
    // Counting engines, one per timer
    // =========================================================
    for (genvar t = 0; t < 2; t++)
    begin : g_timer
        logic wr_here;
        assign wr_here = bus_write & in_range & (timer_sel == 1'(t));

        // Prescaler bit chosen by divide field
        assign active_edge[t] = tick_edge & start_reg[t]
                              & ((prescale_reg[t] & ((8'h01 << div_reg[t]) - 8'h01)) == 8'h00);

        // Next count and overflow per mode
        always_comb
        begin
            count_next[t] = count_reg[t];
            ovf_event[t]  = 1'b0;
            unique case (count_mode_e'(mode_reg[t]))
                MODE_FREE:
                begin
                    count_next[t] = count_reg[t] + 8'h01;
                    ovf_event[t]  = count_reg[t] == COUNT_TOP;
                end
                MODE_MODULO:
                begin
                    ovf_event[t]  = count_reg[t] == period_compare_reg[t];
                    count_next[t] = ovf_event[t] ? 8'h00 : count_reg[t] + 8'h01;
                end
                MODE_DOWN:
                begin
                    if (!down_loaded_reg[t])
                        count_next[t] = period_compare_reg[t];
                    else if (count_reg[t] != 8'h00)
                        count_next[t] = count_reg[t] - 8'h01;
                    ovf_event[t] = down_loaded_reg[t] & (count_reg[t] == 8'h01);
                end
                MODE_UPDOWN:
                begin
                    if (down_dir_reg[t] && count_reg[t] != 8'h00)
                        count_next[t] = count_reg[t] - 8'h01;
                    else if (count_reg[t] == period_compare_reg[t])
                        count_next[t] = count_reg[t] - 8'h01;
                    else
                        count_next[t] = count_reg[t] + 8'h01;
                    ovf_event[t] = down_dir_reg[t] & (count_reg[t] == 8'h00);
                end
            endcase
            if (!active_edge[t])
            begin
                count_next[t] = count_reg[t];
                ovf_event[t]  = 1'b0;
            end
        end

        // Compare events; up/down ch0 rides on zero turnaround
        assign ch_event[2*t]   = (mode_reg[t] == MODE_UPDOWN) ? ovf_event[t]
                               : active_edge[t] & (count_reg[t] == period_compare_reg[t]);
        assign ch_event[2*t+1] = active_edge[t] & (count_reg[t] == second_compare_reg[t]);

        // Counter, prescaler and direction
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
            begin
                count_reg[t]       <= RESET_COUNT;
                prescale_reg[t]    <= 8'h00;
                down_dir_reg[t]    <= 1'b0;
                down_loaded_reg[t] <= 1'b0;
            end
            else if (wr_here && local_addr == ADDR_TIMER_CONTROL && bus_wdata[CTL_CLR_BIT])
            begin
                count_reg[t]       <= 8'h00;
                prescale_reg[t]    <= 8'h00;
                down_dir_reg[t]    <= 1'b0;
                down_loaded_reg[t] <= 1'b0;
            end
            else
            begin
                if (tick_edge && start_reg[t])
                    prescale_reg[t] <= prescale_reg[t] + 8'h01;
                if (!start_reg[t] || mode_reg[t] != MODE_DOWN)
                    down_loaded_reg[t] <= 1'b0;
                else if (active_edge[t])
                    down_loaded_reg[t] <= 1'b1;
                if (active_edge[t] && mode_reg[t] == MODE_UPDOWN)
                begin
                    if (count_reg[t] == period_compare_reg[t] && !down_dir_reg[t])
                        down_dir_reg[t] <= 1'b1;
                    else if (count_reg[t] == 8'h00 && down_dir_reg[t])
                        down_dir_reg[t] <= 1'b0;
                end
                count_reg[t] <= count_next[t];
            end
        end

        // Control and compare registers
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
            begin
                div_reg[t]            <= RESET_DIV;
                start_reg[t]          <= RESET_START;
                ovf_mask_reg[t]       <= RESET_OVERFLOW_MASK;
                mode_reg[t]           <= MODE_FREE;
                period_buf_reg[t]     <= RESET_COMPARE;
                period_compare_reg[t] <= RESET_COMPARE;
                second_compare_reg[t] <= RESET_COMPARE;
                chan_mask_reg[2*t]    <= RESET_IM;
                chan_mask_reg[2*t+1]  <= RESET_IM;
                compare_action_reg[2*t]   <= RESET_CMP;
                compare_action_reg[2*t+1] <= RESET_CMP;
            end
            else
            begin
                if (wr_here && local_addr == ADDR_TIMER_CONTROL)
                begin
                    div_reg[t]      <= bus_wdata[CTL_DIV_LSB +: 3];
                    start_reg[t]    <= bus_wdata[CTL_START_BIT];
                    ovf_mask_reg[t] <= bus_wdata[CTL_OVERFLOW_MASK_BIT];
                    mode_reg[t]     <= bus_wdata[CTL_MODE_LSB +: 2];
                end
                if (wr_here && local_addr == ADDR_CHANNEL0_CONTROL)
                begin
                    chan_mask_reg[2*t]      <= bus_wdata[CCTL_IM_BIT];
                    compare_action_reg[2*t] <= bus_wdata[CCTL_CMP_LSB +: 3];
                end
                if (wr_here && local_addr == ADDR_CHANNEL1_CONTROL)
                begin
                    chan_mask_reg[2*t+1]      <= bus_wdata[CCTL_IM_BIT];
                    compare_action_reg[2*t+1] <= bus_wdata[CCTL_CMP_LSB +: 3];
                end
                if (wr_here && local_addr == ADDR_PERIOD_COMPARE)
                    period_buf_reg[t] <= bus_wdata;
                if (count_reg[t] == 8'h00)
                    period_compare_reg[t] <= period_buf_reg[t];
                if (wr_here && local_addr == ADDR_SECOND_COMPARE)
                    second_compare_reg[t] <= bus_wdata;
            end
        end
    end

    // =========================================================
    // Compare pins, one flop each so edges are clean
    // =========================================================
    for (genvar c = 0; c < 4; c++)
    begin : g_pin
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
                pin_reg[c] <= 1'b0;
            else if (ch_event[c])
            begin
                unique case (compare_action_e'(compare_action_reg[c]))
                    CMP_SET, CMP_SET_UP, CMP_SET_CMP0:       pin_reg[c] <= 1'b1;
                    CMP_CLEAR, CMP_CLEAR_UP, CMP_CLEAR_CMP0: pin_reg[c] <= 1'b0;
                    CMP_TOGGLE:                              pin_reg[c] <= ~pin_reg[c];
                    default:                                 pin_reg[c] <= pin_reg[c];
                endcase
            end
        end
        assign compare_pin[c] = pin_reg[c];
    end

    // Channel pins drive once their timer is started
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            compare_pin_oe <= 4'h0;
        else
            compare_pin_oe <= {start_reg[1], start_reg[1], start_reg[0], start_reg[0]};
    end

    // =========================================================
    // Flags, set wins over software clear
    // =========================================================
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            timer_flag_reg <= 6'h00;
        else
        begin
            for (int t = 0; t < 2; t++)
            begin
                if (bus_write && bus_addr == ADDR_TIMER_FLAG)
                begin
                    timer_flag_reg[t*FLAG_STRIDE +: 3] <= bus_wdata[t*FLAG_STRIDE +: 3]
                                                        & timer_flag_reg[t*FLAG_STRIDE +: 3];
                end
                if (ovf_event[t])
                    timer_flag_reg[t*FLAG_STRIDE+FLAG_OVF_BIT] <= 1'b1;
                if (ch_event[2*t])
                    timer_flag_reg[t*FLAG_STRIDE+FLAG_CH0_BIT] <= 1'b1;
                if (ch_event[2*t+1])
                    timer_flag_reg[t*FLAG_STRIDE+FLAG_CH1_BIT] <= 1'b1;
            end
        end
    end

    // CPU flag follows masked flags, so unmasking a pending flag raises it
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cpu_timer_flag_reg <= 2'b00;
            timer_irq          <= 2'b00;
            cpu_enable_reg     <= 2'b00;
        end
        else
        begin
            if (bus_write && bus_addr == ADDR_CPU_ENABLE)
                cpu_enable_reg <= bus_wdata[1:0];
            for (int t = 0; t < 2; t++)
            begin
                cpu_timer_flag_reg[t] <= pending(timer_flag_reg[t*FLAG_STRIDE +: 3],
                    {chan_mask_reg[2*t+1], chan_mask_reg[2*t], ovf_mask_reg[t]});
                timer_irq[t] <= cpu_timer_flag_reg[t] & cpu_enable_reg[t];
            end
        end
    end

    // Fixed vector numbers, one per timer, shared by all its events
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            first_vector  <= VECTOR_FIRST;
            second_vector <= VECTOR_SECOND;
        end
        else
        begin
            first_vector  <= VECTOR_FIRST;
            second_vector <= VECTOR_SECOND;
        end
    end

    // DMA triggers, one cycle per compare
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            dma_reg <= 4'h0;
        else
            dma_reg <= {ch_event[3], ch_event[2], ch_event[1], ch_event[0]};
    end

    assign first_timer_ch0_dma_trigger  = dma_reg[0];
    assign first_timer_ch1_dma_trigger  = dma_reg[1];
    assign second_timer_ch0_dma_trigger = dma_reg[2];
    assign second_timer_ch1_dma_trigger = dma_reg[3];

    // =========================================================
    // Read port, data in the cycle after the strobe
    // =========================================================
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            bus_rdata <= 8'h00;
        else if (!bus_read)
            bus_rdata <= 8'h00;
        else if (bus_addr == ADDR_TIMER_FLAG)
            bus_rdata <= {2'b00, timer_flag_reg};
        else if (bus_addr == ADDR_CPU_ENABLE)
            bus_rdata <= {6'h00, cpu_enable_reg};
        else if (bus_addr == ADDR_CPU_FLAG)
            bus_rdata <= {6'h00, cpu_timer_flag_reg};
        else if (!in_range)
            bus_rdata <= 8'h00;
        else
        begin
            unique case (local_addr)
                ADDR_COUNT_READBACK: bus_rdata <= count_reg[timer_sel];
                ADDR_TIMER_CONTROL:  bus_rdata <= {div_reg[timer_sel], start_reg[timer_sel],
                                                   ovf_mask_reg[timer_sel], 1'b0,
                                                   mode_reg[timer_sel]};
                ADDR_CHANNEL0_CONTROL: bus_rdata <= {1'b0, chan_mask_reg[2*timer_sel],
                                                     compare_action_reg[2*timer_sel], 3'h0};
                ADDR_PERIOD_COMPARE: bus_rdata <= period_buf_reg[timer_sel];
                ADDR_CHANNEL1_CONTROL: bus_rdata <= {1'b0, chan_mask_reg[2*timer_sel+1],
                                                     compare_action_reg[2*timer_sel+1], 3'h0};
                default:             bus_rdata <= second_compare_reg[timer_sel];
            endcase
        end
    end

endmodule

// file: hw/timer_pkg.sv
package timer_pkg;

    // =========================================================
    // Register map, one byte per address
    // =========================================================
    localparam logic [7:0] ADDR_COUNT_READBACK   = 8'hca;
    localparam logic [7:0] ADDR_TIMER_CONTROL    = 8'hcb;
    localparam logic [7:0] ADDR_CHANNEL0_CONTROL = 8'hcc;
    localparam logic [7:0] ADDR_PERIOD_COMPARE   = 8'hcd;
    localparam logic [7:0] ADDR_CHANNEL1_CONTROL = 8'hce;
    localparam logic [7:0] ADDR_SECOND_COMPARE   = 8'hcf;
    localparam logic [7:0] ADDR_TIMER_FLAG       = 8'hd8;
    localparam logic [7:0] ADDR_CPU_ENABLE       = 8'hd9;
    localparam logic [7:0] ADDR_CPU_FLAG         = 8'hda;
    localparam logic [7:0] INSTANCE_STRIDE       = 8'h08;

    // =========================================================
    // Control register fields
    // =========================================================
    localparam int CTL_DIV_LSB   = 5;
    localparam int CTL_START_BIT = 4;
    localparam int CTL_OVERFLOW_MASK_BIT = 3;
    localparam int CTL_CLR_BIT   = 2;
    localparam int CTL_MODE_LSB  = 0;
    localparam int CCTL_IM_BIT   = 6;
    localparam int CCTL_CMP_LSB  = 3;

    // Flag register bits: per timer overflow, ch0, ch1
    localparam int FLAG_OVF_BIT = 0;
    localparam int FLAG_CH0_BIT = 1;
    localparam int FLAG_CH1_BIT = 2;
    localparam int FLAG_STRIDE  = 3;

    // =========================================================
    // Reset values
    // =========================================================
    localparam logic [7:0] RESET_COUNT   = 8'h00;
    localparam logic [2:0] RESET_DIV     = 3'h0;
    localparam logic       RESET_START   = 1'b0;
    localparam logic       RESET_OVERFLOW_MASK   = 1'b1;
    localparam logic       RESET_IM      = 1'b1;
    localparam logic [2:0] RESET_CMP     = 3'h0;
    localparam logic [7:0] RESET_COMPARE = 8'h00;
    localparam logic [7:0] COUNT_TOP     = 8'hff;

    // Vector numbers, first and second timer
    localparam logic [4:0] VECTOR_FIRST  = 5'h0b;
    localparam logic [4:0] VECTOR_SECOND = 5'h0c;

    typedef enum logic [1:0]
    {
        MODE_FREE   = 2'b00,
        MODE_DOWN   = 2'b01,
        MODE_MODULO = 2'b10,
        MODE_UPDOWN = 2'b11
    } count_mode_e;

    // Compare actions; codes 3..6 are PWM styles, 7 is reserved
    typedef enum logic [2:0]
    {
        CMP_SET       = 3'h0,
        CMP_CLEAR     = 3'h1,
        CMP_TOGGLE    = 3'h2,
        CMP_SET_UP    = 3'h3,
        CMP_CLEAR_UP  = 3'h4,
        CMP_SET_CMP0  = 3'h5,
        CMP_CLEAR_CMP0 = 3'h6,
        CMP_RESERVED  = 3'h7
    } compare_action_e;

endpackage

// file: test/timer_checker_sva.sv
// ==========================================
// Port-level checks for the compare timer
// ==========================================
module timer_checker
    import timer_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       timer_tick,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic       bus_write,
    input wire logic       bus_read,
    input wire logic [7:0] bus_rdata,
    input wire logic [3:0] compare_pin_oe,
    input wire logic [1:0] timer_irq,
    input wire logic [4:0] first_vector,
    input wire logic [4:0] second_vector,
    input wire logic       first_timer_ch0_dma_trigger,
    input wire logic       first_timer_ch1_dma_trigger
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       tick_d_reg;
    logic [3:0] tick_age_reg;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // Cycles since the tick rose; saturates so it never wraps to a false match
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tick_d_reg   <= 1'b0;
            tick_age_reg <= 4'hf;
        end
        else
        begin
            tick_d_reg <= timer_tick;
            if (timer_tick && !tick_d_reg)
                tick_age_reg <= 4'h0;
            else if (tick_age_reg != 4'hf)
                tick_age_reg <= tick_age_reg + 4'h1;
        end
    end
    property p_vectors;
        first_vector == VECTOR_FIRST && second_vector == VECTOR_SECOND;
    endproperty
    a_vectors: assert property (p_vectors)
        else $error("vector numbers wrong");
    property p_rdata_idle;
        !$past(bus_read) |-> bus_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");
    property p_dma0_pulse;
        first_timer_ch0_dma_trigger |=> !first_timer_ch0_dma_trigger;
    endproperty
    a_dma0_pulse: assert property (p_dma0_pulse)
        else $error("channel 0 trigger longer than one cycle");
    property p_dma1_tick;
        first_timer_ch1_dma_trigger |-> tick_age_reg <= 4'h6;
    endproperty
    a_dma1_tick: assert property (p_dma1_tick)
        else $error("channel 1 trigger without a tick");
    property p_irq_off;
        bus_write && bus_addr == ADDR_CPU_ENABLE && !bus_wdata[0] |-> ##[1:4] !timer_irq[0];
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("request stays with enable off");
    property p_oe_on;
        bus_write && bus_addr == ADDR_TIMER_CONTROL && bus_wdata[CTL_START_BIT]
            |-> ##[1:4] compare_pin_oe[1:0] == 2'b11;
    endproperty
    a_oe_on: assert property (p_oe_on)
        else $error("pins not driven after start");
    property p_oe_off;
        bus_write && bus_addr == ADDR_TIMER_CONTROL && !bus_wdata[CTL_START_BIT]
            |-> ##[1:4] compare_pin_oe[1:0] == 2'b00;
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("pins still driven after stop");
    property p_t1_oe;
        bus_write && bus_addr == ADDR_TIMER_CONTROL + INSTANCE_STRIDE
            && bus_wdata[CTL_START_BIT] |-> ##[1:4] compare_pin_oe[3:2] == 2'b11;
    endproperty
    a_t1_oe: assert property (p_t1_oe)
        else $error("second timer pins not driven");
endmodule

bind dual_compare_timer timer_checker chk_u (.sys_clk, .rst, .timer_tick, .bus_addr,
    .bus_wdata, .bus_write, .bus_read, .bus_rdata, .compare_pin_oe, .timer_irq,
    .first_vector, .second_vector, .first_timer_ch0_dma_trigger,
    .first_timer_ch1_dma_trigger);

// file: test/tick_source.sv
// ==========================================
// Outside tick source, still between bursts
// ==========================================
module tick_source
(
    input  wire logic sys_clk,
    output logic      timer_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    initial timer_tick = 1'b0;
    // Two cycles high, two low: meets the synchroniser minimum with margin
    task automatic burst(input int n);
        repeat (n)
        begin
            @(posedge sys_clk) timer_tick <= 1'b1;
            repeat (2) @(posedge sys_clk);
            timer_tick <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
endmodule

// file: test/tb_dual_compare_timer.sv
module tb_dual_compare_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk, rst, timer_tick, bus_write, bus_read;
    logic [7:0] bus_addr, bus_wdata, bus_rdata;
    logic [3:0] compare_pin, compare_pin_oe;
    logic [1:0] timer_irq;
    logic [4:0] first_vector, second_vector;
    logic       first_timer_ch0_dma_trigger, first_timer_ch1_dma_trigger;
    logic       second_timer_ch0_dma_trigger, second_timer_ch1_dma_trigger;
    int         bad_count, comparisons, dma1_seen, base;
    dual_compare_timer dut_u (.sys_clk, .rst, .timer_tick, .bus_addr, .bus_wdata,
        .bus_write, .bus_read, .bus_rdata, .compare_pin, .compare_pin_oe, .timer_irq,
        .first_vector, .second_vector, .first_timer_ch0_dma_trigger,
        .first_timer_ch1_dma_trigger, .second_timer_ch0_dma_trigger,
        .second_timer_ch1_dma_trigger);
    tick_source tick_u (.sys_clk, .timer_tick);
    // ==========================================
    // Clock, trigger monitor, bus tasks
    // ==========================================
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (first_timer_ch1_dma_trigger === 1'b1)
            dma1_seen++;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge sys_clk);
        bus_write <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge sys_clk);
        bus_read <= 1'b0;
        #1 chk(nm, e, bus_rdata);
    endtask
    // Ticks, then room for synchroniser, flag and request stages to land
    task automatic run(input int n);
        tick_u.burst(n);
        repeat (8) @(posedge sys_clk);
    endtask
    // ==========================================
    // Scenarios
    // ==========================================
    task automatic t_reset();
        rc(8'hca, 8'h00, "count");
        rc(8'hcb, 8'h08, "control");
        rc(8'hd2, 8'h00, "t1 count");
        rc(8'h00, 8'h00, "unmapped");
    endtask
    task automatic t_free();
        wr(8'hcc, 8'h18);
        wr(8'hce, 8'h00);
        wr(8'hd9, 8'h01);
        wr(8'hcb, 8'h10);
        run(10);
        rc(8'hca, 8'h0a, "free count");
        chk("pwm pin", 8'h01, {7'h00, compare_pin[0]});
        run(246);
        rc(8'hca, 8'h00, "free wrap");
        rc(8'hd8, 8'h07, "free flags");
        chk("irq masked", 8'h00, {6'h00, timer_irq});
        wr(8'hcb, 8'h18);
        repeat (4) @(posedge sys_clk);
        chk("irq unmasked", 8'h01, {6'h00, timer_irq});
        rc(8'hda, 8'h01, "cpu flags");
        wr(8'hd9, 8'h00);
        wr(8'hd8, 8'h00);
    endtask
    task automatic t_clear();
        wr(8'hcb, 8'h04);
        rc(8'hca, 8'h00, "cleared count");
        rc(8'hcb, 8'h00, "clear bit");
    endtask
    task automatic t_modulo();
        wr(8'hcd, 8'h03);
        wr(8'hcb, 8'h12);
        run(5);
        rc(8'hca, 8'h01, "modulo count");
        rc(8'hd8, 8'h07, "modulo flags");
        wr(8'hcd, 8'h07);
        run(8);
        rc(8'hca, 8'h05, "period reload");
    endtask
    task automatic t_down();
        wr(8'hcb, 8'h04);
        wr(8'hcd, 8'h04);
        wr(8'hd8, 8'h00);
        wr(8'hcb, 8'h31);
        run(4);
        rc(8'hca, 8'h03, "down count");
        run(8);
        rc(8'hca, 8'h00, "down rest");
        rc(8'hd8, 8'h07, "down flags");
    endtask
    task automatic t_updown();
        wr(8'hcb, 8'h04);
        wr(8'hcd, 8'h02);
        wr(8'hd8, 8'h00);
        wr(8'hcb, 8'h13);
        run(3);
        rc(8'hca, 8'h01, "falling");
        rc(8'hd8, 8'h04, "peak flags");
        run(2);
        rc(8'hca, 8'h01, "rising");
        rc(8'hd8, 8'h07, "zero flags");
    endtask
    task automatic t_ch1();
        wr(8'hcb, 8'h04);
        wr(8'hce, 8'h10);
        wr(8'hcf, 8'h09);
        wr(8'hcb, 8'h10);
        run(2);
        base = dma1_seen;
        chk("pin held", 8'h01, {7'h00, compare_pin[1]});
        wr(8'hcf, 8'h03);
        run(2);
        chk("pin toggled", 8'h00, {7'h00, compare_pin[1]});
        chk("dma pulses", 8'h01, 8'(dma1_seen - base));
        wr(8'hd3, 8'h10);
        run(1);
        rc(8'hd3, 8'h10, "t1 control");
        chk("t1 pins", 8'h03, {6'h00, compare_pin[3:2]});
        wr(8'hd3, 8'h00);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Under 1400 cycles suffice; far beyond that means a hang
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        wrap_up();
    end
    initial
    begin
        sys_clk   = 1'b0;
        rst       = 1'b1;
        bus_addr  = 8'h00;
        bus_wdata = 8'h00;
        bus_write = 1'b0;
        bus_read  = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_free();
        t_clear();
        t_modulo();
        t_down();
        t_updown();
        t_ch1();
        wrap_up();
    end
endmodule
